// ==== src/mrs_reset_seq.sv ====
// Reset sequencer top: merges reset sources, times the release, keeps
// the timeout/power-down status, and exposes registers over APB.
// Assumes all inputs synchronous to pclk; presetn is the power-up reset.
//
// What this block does
// [RL1] Five sources reset the core
// [RL2] Fetch from 3ffh, a nop wraps to 000h
// [RL3] Cause sets timeout and power-down bits
// [RL4] Status word resets to 00011xxx or 000qquuu
// [RL5] Arithmetic flags survive internal resets
// [RL6] Wake-up from halt is a full reset
// [RL7] Power-up holds until pin high, then timer
// [RL8] Power-on resets only on rising supply
// [RL9] Timer length is selectable, core held meanwhile
// [RL10] Watchdog timeout restarts the reset timer
// [RL11] Port zero falling edge wakes from halt
// [RL12] Low-voltage option turns clear pin into input
// [RL13] Watchdog clear and halt update status bits
// [RL14] Low clear pin holds reset, timer restarts
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module mrs_reset_seq #(
    parameter int unsigned SHORT_CYC = mrs_pkg::DRT_SHORT_CYC,
    parameter int unsigned LONG_CYC  = mrs_pkg::DRT_LONG_CYC
) (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [mrs_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [31:0]                  pwdata,
    output logic [31:0]                       prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic                         supply_ok,
    input  wire logic                         low_voltage_reset,
    input  wire logic                         external_clear_pin,
    input  wire logic [mrs_pkg::P0_W-1:0]     port_zero,
    input  wire logic                         watchdog_timer,
    input  wire mrs_pkg::mrs_core_req_t       core_req,
    output logic                              core_reset_n,
    output logic [9:0]                        fetch_addr,
    output logic                              halted,
    output logic                              irq
);
    import mrs_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        mrs_state_t        st;
        logic [1:0]        cfg;
        logic [NUM_EV-1:0] irq_stat;
        logic [NUM_EV-1:0] irq_mask;
        logic              timeout_flag;
        logic              powerdown_flag;
        logic [2:0]        arith;
        logic [NUM_EV-1:0] cause;
        logic [9:0]        fetch_addr;
        logic              supply_prev;
        logic              drt_start;
        logic [31:0]       prdata;
        logic              pslverr;
    } mrs_top_st_t;

    mrs_top_st_t s_q, s_d;

    logic              drt_done;
    logic              p0_fall;
    logic              pin_is_reset;
    logic              pin_rst;
    logic              lvr_rst;
    logic              por_ev;
    logic              wdt_ev;
    logic              p0_ev;
    logic              in_halt;
    logic              setup;
    logic              acc_wr;
    logic [3:0]        idx;
    logic              mapped;
    logic [NUM_EV-1:0] ev;
    logic [7:0]        status_word;

    // ------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------
    mrs_drt #(
        .SHORT_CYC (SHORT_CYC),
        .LONG_CYC  (LONG_CYC)
    ) u_drt (
        .pclk     (pclk),
        .presetn  (presetn),
        .start    (s_q.drt_start),
        .hold     (s_q.st == ST_HOLD),
        .long_sel (s_q.cfg[CFG_LONG_BIT]),
        .done     (drt_done)
    );

    mrs_p0_wake #(
        .N (P0_W)
    ) u_p0 (
        .pclk    (pclk),
        .presetn (presetn),
        .pins    (port_zero),
        .fall    (p0_fall)
    );

    // ------------------------------------------------------------
    // Reset sources
    // ------------------------------------------------------------
    assign in_halt      = (s_q.st == ST_HALT);
    assign pin_is_reset = ~s_q.cfg[CFG_LVR_BIT];                     // [RL12]
    assign pin_rst      = pin_is_reset & ~external_clear_pin;         // [RL14]
    assign lvr_rst      = s_q.cfg[CFG_LVR_BIT] & low_voltage_reset;   // [RL1]
    assign por_ev       = supply_ok & ~s_q.supply_prev;              // [RL8]
    assign wdt_ev       = watchdog_timer & (s_q.st != ST_HOLD);      // [RL10]
    assign p0_ev        = in_halt & p0_fall;                         // [RL11]

    assign status_word = {3'h0, s_q.timeout_flag, s_q.powerdown_flag, s_q.arith};

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign setup  = psel & ~penable;
    assign acc_wr = psel & penable & pwrite & ~s_q.pslverr;
    assign idx    = paddr[ADDR_LSB +: 4];
    assign mapped = (paddr[ADDR_W-1:ADDR_LSB+4] == '0) & (idx <= IDX_CAUSE)
                  & (paddr[ADDR_LSB-1:0] == '0);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d             = s_q;
        ev              = '0;
        s_d.supply_prev = supply_ok;
        s_d.drt_start   = 1'b0;

        if (por_ev) begin
            // Power-on: full 1,1 and wait for the pin
            s_d.st             = ST_HOLD;                                // [RL1]
            s_d.timeout_flag   = 1'b1;                                   // [RL3]
            s_d.powerdown_flag = 1'b1;                                   // [RL4]
            ev[EV_POR]         = 1'b1;
        end else if (lvr_rst) begin
            s_d.st             = ST_HOLD;                                // [RL1]
            s_d.timeout_flag   = 1'b1;
            s_d.powerdown_flag = 1'b1;
            ev[EV_LVR]         = 1'b1;
        end else if (pin_rst) begin
            // Held for as long as the pin stays low
            if (s_q.st != ST_HOLD) begin
                ev[EV_PIN] = 1'b1;
            end
            if (in_halt) begin
                s_d.timeout_flag   = 1'b1;                               // [RL3]
                s_d.powerdown_flag = 1'b0;                               // [RL6]
            end
            s_d.st = ST_HOLD;                                            // [RL14]
        end else if (wdt_ev) begin
            s_d.timeout_flag   = 1'b0;                                   // [RL3]
            s_d.powerdown_flag = ~in_halt;                               // [RL6]
            s_d.st             = ST_COUNT;
            s_d.drt_start      = 1'b1;                                   // [RL10]
            ev[EV_WDT]         = 1'b1;
        end else if (p0_ev) begin
            s_d.timeout_flag   = 1'b1;
            s_d.powerdown_flag = 1'b0;
            s_d.st             = ST_COUNT;                               // [RL11]
            s_d.drt_start      = 1'b1;
            ev[EV_P0]          = 1'b1;
        end else begin
            case (s_q.st)
                ST_HOLD: begin
                    // Latch set, timer cleared until pin reads high
                    s_d.st        = ST_COUNT;                            // [RL7]
                    s_d.drt_start = 1'b1;
                end
                ST_COUNT: begin
                    if (drt_done) begin
                        s_d.st         = ST_RUN;                         // [RL9]
                        s_d.fetch_addr = RESET_VECTOR;                   // [RL2]
                        ev[EV_REL]     = 1'b1;
                    end
                end
                ST_RUN: begin
                    if (core_req.halt) begin
                        s_d.st             = ST_HALT;
                        s_d.timeout_flag   = 1'b1;                       // [RL13]
                        s_d.powerdown_flag = 1'b0;
                    end else if (core_req.watchdog_clear_instr) begin
                        s_d.timeout_flag   = 1'b1;                       // [RL13]
                        s_d.powerdown_flag = 1'b1;
                    end
                    if (core_req.vec_nop && s_q.fetch_addr == RESET_VECTOR) begin
                        s_d.fetch_addr = WRAP_VECTOR;                    // [RL2]
                    end
                end
                ST_HALT: begin
                    s_d.st = ST_HALT;
                end
                default: begin
                    s_d.st = ST_HOLD;
                end
            endcase
        end

        if (ev != '0) begin
            s_d.cause = ev;
        end

        // Arithmetic flags: never touched by internal resets
        if (acc_wr && idx == IDX_STATUS) begin
            s_d.arith = pwdata[2:0];                                     // [RL5]
        end
        if (core_req.flags_we && s_q.st == ST_RUN) begin
            s_d.arith = core_req.flags_wdata;
        end

        // Register writes
        if (acc_wr && idx == IDX_CFG) begin
            s_d.cfg = pwdata[1:0];
        end
        if (acc_wr && idx == IDX_IRQ_MASK) begin
            s_d.irq_mask = pwdata[NUM_EV-1:0];
        end
        if (acc_wr && idx == IDX_IRQ_STAT) begin
            s_d.irq_stat = s_q.irq_stat & ~pwdata[NUM_EV-1:0];
        end
        // Set wins over a same-cycle clear
        s_d.irq_stat = s_d.irq_stat | ev;

        // Read data captured in setup, so the access phase has no wait
        if (setup) begin
            s_d.pslverr = ~mapped;
            case (idx)
                IDX_CFG:      s_d.prdata = {30'h0, s_q.cfg};
                IDX_IRQ_STAT: s_d.prdata = {26'h0, s_q.irq_stat};
                IDX_IRQ_MASK: s_d.prdata = {26'h0, s_q.irq_mask};
                IDX_STATUS:   s_d.prdata = {24'h0, status_word};
                IDX_CAUSE:    s_d.prdata = {26'h0, s_q.cause};
                default:      s_d.prdata = 32'h0;
            endcase
            if (!mapped) begin
                s_d.prdata = 32'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Power-up: reset latch set, timer cleared, status 00011 with
    // arithmetic flags at an arbitrary but defined zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q                <= '0;
            s_q.st             <= ST_HOLD;                               // [RL7]
            s_q.cfg            <= CFG_RST;
            s_q.timeout_flag   <= 1'b1;                                  // [RL4]
            s_q.powerdown_flag <= 1'b1;
            s_q.irq_stat       <= 6'h01;
            s_q.cause          <= 6'h01;
            s_q.supply_prev    <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign core_reset_n = (s_q.st == ST_RUN) | (s_q.st == ST_HALT);    // [RL9]
    assign fetch_addr   = s_q.fetch_addr;
    assign halted       = in_halt;
    assign irq          = |(s_q.irq_stat & s_q.irq_mask);
    assign prdata       = s_q.prdata;
    assign pready       = 1'b1;
    assign pslverr      = psel & penable & s_q.pslverr;

endmodule : mrs_reset_seq
`default_nettype wire

// ==== src/mrs_pkg.sv ====
// Package for the reset sequencer: register map, fields, states, timing.
// Assumes a single 250 MHz clock domain (pclk) and an APB register bus.
package mrs_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam longint unsigned CLK_MHZ      = 64'd250;
    localparam longint unsigned DRT_SHORT_NS = 64'd560000;
    localparam longint unsigned DRT_LONG_NS  = 64'd18000000;
    // Rounded down; timer lengths are nominal delays, not bounds
    localparam int unsigned DRT_SHORT_CYC = 32'(DRT_SHORT_NS * CLK_MHZ / 64'd1000);
    localparam int unsigned DRT_LONG_CYC  = 32'(DRT_LONG_NS * CLK_MHZ / 64'd1000);
    localparam int unsigned DRT_W         = 32;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [3:0] IDX_CFG      = 4'h0;
    localparam logic [3:0] IDX_IRQ_STAT = 4'h1;
    localparam logic [3:0] IDX_IRQ_MASK = 4'h2;
    localparam logic [3:0] IDX_STATUS   = 4'h3;
    localparam logic [3:0] IDX_CAUSE    = 4'h4;
    localparam int unsigned ADDR_LSB    = 2;
    localparam int unsigned ADDR_W      = 12;

    // ------------------------------------------------------------
    // Fields
    // ------------------------------------------------------------
    localparam int unsigned CFG_LVR_BIT  = 0;
    localparam int unsigned CFG_LONG_BIT = 1;
    localparam int unsigned ST_TO_BIT    = 4;
    localparam int unsigned ST_PD_BIT    = 3;
    localparam int unsigned NUM_EV       = 6;
    localparam int unsigned EV_POR       = 0;
    localparam int unsigned EV_LVR       = 1;
    localparam int unsigned EV_PIN       = 2;
    localparam int unsigned EV_P0        = 3;
    localparam int unsigned EV_WDT       = 4;
    localparam int unsigned EV_REL       = 5;

    localparam logic [9:0] RESET_VECTOR = 10'h3ff;
    localparam logic [9:0] WRAP_VECTOR  = 10'h000;
    localparam logic [1:0] CFG_RST      = 2'h0;
    localparam int unsigned P0_W        = 7;

    typedef enum logic [3:0] {
        ST_HOLD  = 4'h1,
        ST_COUNT = 4'h2,
        ST_RUN   = 4'h4,
        ST_HALT  = 4'h8
    } mrs_state_t;

    // Core side requests, one-cycle strobes except the flag data
    typedef struct packed {
        logic       watchdog_clear_instr;
        logic       halt;
        logic       vec_nop;
        logic       flags_we;
        logic [2:0] flags_wdata;
    } mrs_core_req_t;

endpackage : mrs_pkg

// ==== src/mrs_drt.sv ====
// Device reset timer: counts a selectable number of cycles after a start.
// Assumes start and hold come from registered control logic.
`timescale 1ns/1ps
`default_nettype none
module mrs_drt #(
    parameter int unsigned SHORT_CYC = mrs_pkg::DRT_SHORT_CYC,
    parameter int unsigned LONG_CYC  = mrs_pkg::DRT_LONG_CYC
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic start,
    input  wire logic hold,
    input  wire logic long_sel,
    output logic      done
);
    import mrs_pkg::*;

    typedef struct packed {
        logic             busy;
        logic             done;
        logic [DRT_W-1:0] cnt;
    } mrs_drt_st_t;

    mrs_drt_st_t s_q, s_d;

    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (hold) begin
            s_d.busy = 1'b0;
            s_d.cnt  = '0;
        end else if (start) begin
            s_d.busy = 1'b1;
            s_d.cnt  = long_sel ? DRT_W'(LONG_CYC) : DRT_W'(SHORT_CYC);
        end else if (s_q.busy) begin
            s_d.cnt = s_q.cnt - DRT_W'(1);
            if (s_q.cnt <= DRT_W'(1)) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign done = s_q.done;

endmodule : mrs_drt
`default_nettype wire

// ==== src/mrs_p0_wake.sv ====
// High-to-low change detector over the port zero pins.
// Assumes pins are synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module mrs_p0_wake #(
    parameter int unsigned N = mrs_pkg::P0_W
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [N-1:0] pins,
    output logic              fall
);
    import mrs_pkg::*;

    logic [N-1:0] prev_q;
    logic [N-1:0] fall_bit;

    // Idle level is high, so a pin already low at release fires once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= '1;
        end else begin
            prev_q <= pins;
        end
    end

    for (genvar i = 0; i < N; i++) begin : g_pin
        assign fall_bit[i] = prev_q[i] & ~pins[i];
    end

    assign fall = |fall_bit;

endmodule : mrs_p0_wake
`default_nettype wire

// ==== verification/mrs_core_model.sv ====
// Core model: turns bench commands into one-cycle core requests.
// Assumes a core held in reset or halted executes nothing.
`timescale 1ns/1ps
`default_nettype none
module mrs_core_model (
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           core_reset_n,
    input  wire logic           halted,
    input  wire logic [1:0]     op,
    input  wire logic           go,
    output mrs_pkg::mrs_core_req_t core_req
);
    import mrs_pkg::*;
    // ----------------------------------------
    // Request strobes
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_req <= '0;
        end else begin
            core_req <= '0;
            // A stopped core issues nothing, so no request hides a wake-up
            if (go && core_reset_n && !halted) begin
                case (op)
                    2'd0: core_req.watchdog_clear_instr <= 1'b1;
                    2'd1: core_req.halt <= 1'b1;
                    2'd2: core_req.vec_nop <= 1'b1;
                    default: begin
                        core_req.flags_we <= 1'b1;
                        core_req.flags_wdata <= 3'h5;
                    end
                endcase
            end
        end
    end
endmodule : mrs_core_model
`default_nettype wire

// ==== verification/mrs_reset_seq_monitor.sv ====
// Checker on the sequencer's top ports.
// Assumes one pclk domain and async active-low presetn.
`timescale 1ns/1ps
`default_nettype none
module mrs_reset_seq_monitor
    import mrs_pkg::*;
#(
    parameter int unsigned SHORT_CYC = 10,
    parameter int unsigned LONG_CYC  = 20
) (
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       supply_ok,
    input wire logic                       low_voltage_reset,
    input wire logic                       external_clear_pin,
    input wire logic [mrs_pkg::P0_W-1:0]   port_zero,
    input wire logic                       watchdog_timer,
    input wire mrs_pkg::mrs_core_req_t     core_req,
    input wire logic                       core_reset_n,
    input wire logic [9:0]                 fetch_addr,
    input wire logic                       halted
);
    // ----------------------------------------
    // Helper: cycles spent in reset
    // ----------------------------------------
    logic [31:0] low_cnt_q;
    logic [31:0] low_cnt_d;
    always_comb low_cnt_d = core_reset_n ? 32'h0 : low_cnt_q + 32'h1;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) low_cnt_q <= '0;
        else low_cnt_q <= low_cnt_d;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_vec; $rose(core_reset_n) |-> fetch_addr == RESET_VECTOR && !halted; endproperty
    a_vec: assert property (p_vec) else $error("bad release state");
    property p_nop; core_reset_n && !halted && core_req.vec_nop && fetch_addr == RESET_VECTOR
        |=> fetch_addr == WRAP_VECTOR; endproperty
    a_nop: assert property (p_nop) else $error("no wrap");
    property p_wdt; core_reset_n && watchdog_timer |=> !core_reset_n; endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog ignored");
    property p_halt; core_reset_n && !halted && core_req.halt |=> halted; endproperty
    a_halt: assert property (p_halt) else $error("no halt");
    property p_p0; halted && (|($past(port_zero) & ~port_zero)) |-> ##[1:2] !core_reset_n; endproperty
    a_p0: assert property (p_p0) else $error("no wake");
    property p_por; $rose(supply_ok) |=> !core_reset_n; endproperty
    a_por: assert property (p_por) else $error("no power-on");
    property p_fall; $fell(supply_ok) && core_reset_n && external_clear_pin && !low_voltage_reset
        && !watchdog_timer |=> core_reset_n; endproperty
    a_fall: assert property (p_fall) else $error("reset on fall");
    property p_pin; !core_reset_n && !external_clear_pin |=> !core_reset_n; endproperty
    a_pin: assert property (p_pin) else $error("pin released");
    property p_min; $rose(core_reset_n) |-> low_cnt_q >= SHORT_CYC; endproperty
    a_min: assert property (p_min) else $error("timer short");
endmodule : mrs_reset_seq_monitor
bind mrs_reset_seq mrs_reset_seq_monitor #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_mon (
    .pclk, .presetn, .supply_ok, .low_voltage_reset, .external_clear_pin, .port_zero,
    .watchdog_timer, .core_req, .core_reset_n, .fetch_addr, .halted);
`default_nettype wire

// ==== verification/mrs_reset_seq_tb.sv ====
// Bench for the sequencer: APB tasks, core model, table of reset cases.
// Assumes short timer parameters and a zero-wait APB slave.
`timescale 1ns/1ps
`default_nettype none
module mrs_reset_seq_tb;
    import mrs_pkg::*;
    localparam int unsigned SC = 10;
    localparam int unsigned LC = 20;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
    logic        supply_ok = 1, low_voltage_reset = 0, external_clear_pin = 1, watchdog_timer = 0;
    logic        pready, pslverr, core_reset_n, halted, irq, e;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic [6:0]  port_zero = 7'h7f;
    logic [1:0]  op = '0;
    logic [9:0]  fetch_addr;
    int          err_total = 0, tests_run = 0, n;
    mrs_core_req_t core_req;
    always #2 pclk = ~pclk;
    mrs_reset_seq #(.SHORT_CYC(SC), .LONG_CYC(LC)) uut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .supply_ok, .low_voltage_reset, .external_clear_pin,
        .port_zero, .watchdog_timer, .core_req, .core_reset_n, .fetch_addr, .halted, .irq);
    mrs_core_model cm (.pclk, .presetn, .core_reset_n, .halted, .op, .go, .core_req);
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("Checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            err_total++;
            tally_and_finish();
        end
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(0, a, 0);
        chk(r, exp);
    endtask : rd
    task automatic wfor(input logic lvl, input int lim);
        n = 0;
        while (core_reset_n !== lvl && n < lim) begin
            @(posedge pclk);
            n++;
        end
        if (n >= lim) begin
            err_total++;
            tally_and_finish();
        end
    endtask : wfor
    task automatic core(input logic [1:0] o);
        @(posedge pclk);
        op <= o;
        go <= 1;
        @(posedge pclk);
        go <= 0;
        repeat (3) @(posedge pclk);
    endtask : core
    task automatic ck_irq(input logic exp);
        @(posedge pclk);
        chk(irq, exp);
    endtask : ck_irq
    // Sources: 0 watchdog, 1 pin, 2 port zero, 3 low voltage, 4 supply rise
    task automatic rcase(input int src, input logic hlt, input logic [1:0] cfg, input logic [7:0] exp);
        apb(1, 12'h000, {30'h0, cfg});
        if (hlt) core(2'd1);
        if (src == 3) external_clear_pin <= 0;
        if (src == 4) supply_ok <= 0;
        repeat (5) @(posedge pclk);
        chk(core_reset_n, 1);
        // Only the low-voltage case left the pin low; one assignment per step
        if (src == 3) external_clear_pin <= 1;
        case (src)
            0: watchdog_timer <= 1;
            1: external_clear_pin <= 0;
            2: port_zero <= 7'h77;
            3: low_voltage_reset <= 1;
            default: supply_ok <= 1;
        endcase
        @(posedge pclk);
        watchdog_timer <= 0;
        low_voltage_reset <= 0;
        port_zero <= 7'h7f;
        wfor(0, 5);
        if (src == 1) begin
            repeat (30) @(posedge pclk);
            chk(core_reset_n, 0);
            external_clear_pin <= 1;
        end
        wfor(1, 200);
        chk(n >= (cfg[1] ? LC : SC) - 2, 1);
        chk(fetch_addr, 10'h3ff);
        chk(halted, 0);
        rd(12'h00c, {24'h0, exp});
    endtask : rcase
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    int          src_a[9] = '{0, 1, 0, 2, 0, 1, 3, 0, 4};
    logic        hlt_a[9] = '{0, 0, 1, 1, 0, 1, 0, 0, 0};
    logic [1:0]  cfg_a[9] = '{0, 0, 0, 0, 2, 0, 1, 0, 0};
    logic [7:0]  exp_a[9] = '{8'h0d, 8'h0d, 8'h05, 8'h15, 8'h0d, 8'h15, 8'h1d, 8'h0d, 8'h1d};
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        wfor(1, 200);
        chk(fetch_addr, 10'h3ff);
        rd(12'h00c, 32'h18);
        apb(0, 12'h004, 0);
        chk(r[0], 1);
        core(2'd2);
        chk(fetch_addr, 10'h000);
        core(2'd3);
        rd(12'h00c, 32'h1d);
        core(2'd1);
        chk(halted, 1);
        rd(12'h00c, 32'h15);
        core(2'd1);
        core(2'd0);
        rd(12'h00c, 32'h15);
        rcase(2, 0, 0, 8'h15);
        core(2'd0);
        rd(12'h00c, 32'h1d);
        port_zero <= 7'h7e;
        repeat (4) @(posedge pclk);
        port_zero <= 7'h7f;
        chk(core_reset_n, 1);
        for (int i = 0; i < 9; i++) rcase(src_a[i], hlt_a[i], cfg_a[i], exp_a[i]);
        apb(1, 12'h004, 32'h3f);
        apb(1, 12'h008, 32'h10);
        ck_irq(0);
        rcase(0, 0, 0, 8'h0d);
        ck_irq(1);
        apb(1, 12'h008, 32'h0);
        ck_irq(0);
        apb(1, 12'h008, 32'h10);
        ck_irq(1);
        apb(1, 12'h004, 32'h10);
        ck_irq(0);
        apb(1, 12'h00c, 32'h2);
        rd(12'h00c, 32'h0a);
        apb(0, 12'h040, 0);
        chk(e, 1);
        chk(r, 0);
        tally_and_finish();
    end
endmodule : mrs_reset_seq_tb
`default_nettype wire
